// ---- dv/dmfc_ctrl_model.sv ----
/*
 * Controller stand-in that issues one-cycle decoded commands to the block.
 * Assumes the bench calls its tasks and that it shares the block clock.
 */
`timescale 1ns/1ps
`default_nettype none
module dmfc_ctrl_model (
    input  wire logic   clk,
    output logic [9:0]  stb,
    output logic [21:0] addr,
    output logic [3:0]  bank,
    output logic [17:0] row
);
    // All lines start quiet, so no command is seen before the first call.
    initial begin
        stb  = '0;
        addr = '0;
        bank = '0;
        row  = '0;
    end

    // Drives one command for exactly one cycle. Released lines are inverted
    // so that a stale address can never pass for a fresh one.
    task automatic issue(input int k, input logic [21:0] a, input logic [3:0] b,
                         input logic [17:0] r);
        @(posedge clk);
        #1;
        stb[k] = 1'b1;
        addr   = a;
        bank   = b;
        row    = r;
        @(posedge clk);
        #1;
        stb[k] = 1'b0;
        addr   = ~a;
        bank   = ~b;
        row    = ~r;
    endtask : issue

    // Mode register write. Gear-down is never used, so any latency code is legal.
    task automatic mrs(input logic [2:0] sel, input logic [12:0] v);
        issue(0, {1'b0, sel, 5'h00, v}, 4'h0, 18'h00000);
    endtask : mrs
endmodule : dmfc_ctrl_model
`default_nettype wire

// ---- dv/test_dmfc.sv ----
/*
 * Self-checking bench for the mode-register feature control block.
 * Assumes the controller model drives commands; the bench drives levels.
 */
`timescale 1ns/1ps
`default_nettype none
module test_dmfc;
    import dmfc_pkg::*;
    typedef struct { int at; int sel; logic [21:0] val; } dmfc_exp_type;
    dmfc_exp_type q[$];               // Pending expectations, oldest first.
    logic clk = 1'b0;
    logic srst, rst_pin_n, temp_cool, power_down;
    logic [9:0] stb;
    logic [21:0] addr, v, e5, mr4, mr5;
    logic [3:0] bank, cal;
    logic [17:0] row;
    logic hit, cap, pchk, rexec, rpre, wpre, rtrain, msave, ext, vmon;
    logic [2:0] plat;
    logic [7:0] multipurpose_readout;
    int cyc = 0;                      // Cycle stamp for expectations.
    int err_count = 0;
    int num_checks = 0;
    int seed = 45015;
    int n;
    int cl[5] = '{3, 4, 5, 6, 8};
    int pl[8] = '{0, 4, 5, 6, 0, 0, 0, 0};
    string nm[15] = '{"mr5", "mr4", "capture", "refresh", "wr_pre", "rd_pre", "hit",
                      "par_lat", "par_chk", "readout", "max_save", "range", "cal", "train",
                      "vref_mon"};

    dmfc_ctrl_model ctrl (.clk(clk), .stb(stb), .addr(addr), .bank(bank), .row(row));

    dmfc_top dut (.REF_CLK(clk), .SRST(srst), .RESET_N_PIN(rst_pin_n), .MRS_STB(stb[0]),
        .MRS_ADDR(addr), .MPS_EXIT_STB(stb[1]), .CS_LOW_STB(stb[2]), .PAR_ERR_STB(stb[3]),
        .CRC_ERR_STB(stb[4]), .REF_CMD_STB(stb[5]), .TEMP_COOL(temp_cool), .READ_STB(stb[6]),
        .WRITE_STB(stb[7]), .REPAIR_STB(stb[8]), .REPAIR_BANK(bank), .REPAIR_ROW(row),
        .ACT_STB(stb[9]), .ACT_BANK(bank), .ACT_ROW(row), .POWER_DOWN(power_down),
        .REPAIR_HIT(hit), .CA_CAPTURE(cap), .PAR_CHECK_EN(pchk), .REF_EXEC(rexec),
        .RD_PREAMBLE(rpre), .WR_PREAMBLE(wpre), .RD_TRAINING(rtrain),
        .IN_MAX_SAVING(msave), .EXT_TEMP_RANGE(ext), .VREF_MONITOR_EN(vmon),
        .CAL_CLOCKS(cal), .PARITY_LATENCY(plat), .MPR_PAGE2_REG0(multipurpose_readout),
        .MODE_REGISTER_FOUR(mr4), .MODE_REGISTER_FIVE(mr5));

    // Free-running clock and cycle counter.
    always #20 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    // Compares one value and counts the result.
    task automatic check(string name, logic [21:0] seen, logic [21:0] exp);
        num_checks++;
        if (seen !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
            err_count++;
        end
    endtask : check

    // Notes an expected value for output s, d cycles from now.
    task automatic note(int s, logic [21:0] x, int d);
        q.push_back('{cyc + d, s, x});
    endtask : note

    // Waits k edges, then steps off the edge.
    task automatic tick(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask : tick

    // Fifth register write; status bits are never written as one here.
    task automatic wr5(logic [12:0] x);
        ctrl.mrs(3'h5, x);
        e5 = {9'h0A0, x};
        note(0, e5, 0);
    endtask : wr5

    // Fourth register write; bits 13 and 0 are not kept.
    task automatic wr4(logic [12:0] x);
        ctrl.mrs(3'h4, x);
        note(1, {9'h080, x[12:1], 1'b0}, 0);
    endtask : wr4

    // Prints the counts and the verdict, then stops.
    task automatic conclude();
        // A note still pending was never compared, so it counts as a mismatch.
        err_count += q.size();
        $display("checks %0d, mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : conclude

    // Settled outputs are compared mid-cycle against notes due this cycle.
    always @(negedge clk) begin
        logic [21:0] o [15];
        o = '{mr5, mr4, cap, rexec, wpre, rpre, hit, plat, pchk, multipurpose_readout, msave, ext, cal, rtrain,
              vmon};
        for (int i = 0; i < q.size(); i++) begin
            if (q[i].at == cyc) begin
                check(nm[q[i].sel], o[q[i].sel], q[i].val);
                q.delete(i);
                i--;
            end
        end
    end

    // A hang is cut short well past the expected run length.
    initial begin
        repeat (3000) @(posedge clk);
        err_count++;
        conclude();
    end

    // Main sequence.
    initial begin
        srst = 1'b1;
        rst_pin_n = 1'b1;
        temp_cool = 1'b0;
        power_down = 1'b0;
        tick(20);
        srst = 1'b0;
        tick(2);
        note(0, 22'h140000, 0);
        note(1, 22'h100000, 0);
        note(9, 22'h40, 0);
        // Every parity latency and parked termination code, status bits clear, other fields random.
        for (int c = 0; c < 8; c++) begin
            v = $random(seed);
            v[8:0] = {c[2:0], v[5], 2'h0, c[2:0]};
            wr5(v[12:0]);
            note(7, pl[c], 0);
        end
        // Other select codes must not touch the fifth register.
        for (int s = 0; s < 8; s++) begin
            if (s != 4 && s != 5) begin
                v = $random(seed);
                ctrl.mrs(s[2:0], v[12:0]);
                note(0, e5, 0);
            end
        end
        // Parity error stops checking unless persistent; errors are sticky.
        wr5(13'h0001);
        ctrl.issue(3, 0, 0, 0);
        note(0, e5 | 22'h10, 0);
        note(8, 0, 0);
        wr5(13'h0201);
        ctrl.issue(3, 0, 0, 0);
        ctrl.issue(4, 0, 0, 0);
        note(8, 1, 0);
        wr4(13'h0000);
        note(0, e5 | 22'h18, 0);
        wr5(13'h0000);
        // Latency zero: capture on the edge after chip select.
        ctrl.issue(2, 0, 0, 0);
        note(2, 1, 0);
        note(2, 0, 1);
        // Capture comes exactly the programmed count after chip select.
        for (int c = 1; c < 6; c++) begin
            wr4({c[2:0], 6'h00});
            n = cl[c - 1];
            note(12, n, 0);
            ctrl.issue(2, 0, 0, 0);
            note(2, 0, n - 2);
            note(2, 1, n - 1);
            note(2, 0, n);
            tick(n);
        end
        // Each preamble length pair, with training following the read bit.
        for (int p = 0; p < 4; p++) begin
            wr4({p[1:0], p[0], 10'h000});
            note(13, p[0], 0);
            // The long write preamble costs the controller an extra clock of latency.
            tick(p[1]);
            ctrl.issue(7, 0, 0, 0);
            note(4, 1, 0);
            note(4, p[1], 1);
            note(4, 0, p[1] + 1);
            ctrl.issue(6, 0, 0, 0);
            note(5, 1, 0);
            note(5, p[0], 1);
            note(5, 0, p[0] + 1);
        end
        // A cool die with refresh control skips the second refresh.
        wr4(13'h001C);
        note(11, 1, 0);
        note(14, 1, 0);
        // With the monitor on, settling waits grow; one clock covers 40 ns.
        tick(1);
        temp_cool = 1'b1;
        ctrl.issue(5, 0, 0, 0);
        note(3, 1, 0);
        ctrl.issue(5, 0, 0, 0);
        note(3, 0, 0);
        temp_cool = 1'b0;
        ctrl.issue(5, 0, 0, 0);
        note(3, 1, 0);
        // One row per bank; a new address or power-down revokes it.
        v = $random(seed);
        wr4(13'h0020);
        ctrl.issue(8, 0, 4'h3, v[17:0]);
        ctrl.issue(9, 0, 4'h3, v[17:0]);
        note(6, 1, 0);
        ctrl.issue(8, 0, 4'h3, ~v[17:0]);
        ctrl.issue(9, 0, 4'h3, v[17:0]);
        note(6, 0, 0);
        power_down = 1'b1;
        tick(1);
        power_down = 1'b0;
        ctrl.issue(9, 0, 4'h3, ~v[17:0]);
        note(6, 0, 0);
        // Power saving ignores writes until the exit command.
        wr4(13'h0002);
        note(10, 1, 0);
        ctrl.mrs(3'h5, 13'h01C0);
        note(0, e5, 0);
        ctrl.issue(1, 0, 0, 0);
        note(10, 0, 0);
        note(1, 22'h100000, 0);
        // The reset pin clears the registers.
        wr5(13'h01C0);
        rst_pin_n = 1'b0;
        tick(4);
        rst_pin_n = 1'b1;
        tick(3);
        note(0, 22'h140000, 0);
        tick(12);
        conclude();
    end
endmodule : test_dmfc
`default_nettype wire

// ---- rtl/dmfc_pkg.sv ----
/*
 * Constants, types and decode functions for the mode-register feature
 * control block. Assumes one 25 MHz clock and commands already decoded.
 */
package dmfc_pkg;

    // Mode register word and its select field.
    localparam int unsigned    MR_W       = 22;
    localparam int unsigned    SEL_HI     = 20;
    localparam int unsigned    SEL_LO     = 18;
    localparam logic [2:0]     SEL_MR4    = 3'h4;
    localparam logic [2:0]     SEL_MR5    = 3'h5;

    // Fourth register fields.
    localparam int unsigned    MR4_WPRE   = 12;
    localparam int unsigned    MR4_RPRE   = 11;
    localparam int unsigned    MR4_RTRAIN = 10;
    localparam int unsigned    MR4_CAL_HI = 8;
    localparam int unsigned    MR4_CAL_LO = 6;
    localparam int unsigned    MR4_SOFT_ROW_REPAIR   = 5;
    localparam int unsigned    MR4_VMON   = 4;
    localparam int unsigned    MR4_TCR    = 3;
    localparam int unsigned    MR4_TRANGE = 2;
    localparam int unsigned    MR4_MPS    = 1;
    localparam logic [21:0]    MR4_MASK   = 22'h001FFE;
    localparam logic [21:0]    MR4_RESET  = 22'h000000;

    // Fifth register fields.
    localparam int unsigned    MR5_RDBI   = 12;
    localparam int unsigned    MR5_WDBI   = 11;
    localparam int unsigned    MR5_DMASK  = 10;
    localparam int unsigned    MR5_PERS   = 9;
    localparam int unsigned    MR5_PARK_HI = 8;
    localparam int unsigned    MR5_PARK_LO = 6;
    localparam int unsigned    MR5_ODTPD  = 5;
    localparam int unsigned    MR5_PERR   = 4;
    localparam int unsigned    MR5_CRCERR = 3;
    localparam int unsigned    MR5_PL_HI  = 2;
    localparam int unsigned    MR5_PL_LO  = 0;
    localparam logic [21:0]    MR5_MASK   = 22'h001FFF;
    localparam logic [21:0]    MR5_RESET  = 22'h000000;

    // Readout page two, register zero, and the repair support bit.
    localparam int unsigned    MPR_SOFT_ROW_REPAIR_BIT = 6;
    localparam logic           SOFT_ROW_REPAIR_SUPPORTED = 1'b1;

    // Repair table geometry.
    localparam int unsigned    BANKS      = 16;
    localparam int unsigned    BANK_W     = 4;
    localparam int unsigned    ROW_W      = 18;

    // Power state of the die.
    typedef enum logic [1:0] {
        MODE_RUN     = 2'b01,
        MODE_MAXSAVE = 2'b10
    } dmfc_mode_type;

    // Command-address latency in clocks; reserved codes read as zero.
    function automatic logic [3:0] cal_clocks(input logic [2:0] code);
        case (code)
            3'h1:    cal_clocks = 4'h3;
            3'h2:    cal_clocks = 4'h4;
            3'h3:    cal_clocks = 4'h5;
            3'h4:    cal_clocks = 4'h6;
            3'h5:    cal_clocks = 4'h8;
            default: cal_clocks = 4'h0;
        endcase
    endfunction : cal_clocks

    // Parity latency in clocks; zero means parity is off.
    function automatic logic [2:0] par_clocks(input logic [2:0] code);
        case (code)
            3'h1:    par_clocks = 3'h4;
            3'h2:    par_clocks = 3'h5;
            3'h3:    par_clocks = 3'h6;
            default: par_clocks = 3'h0;
        endcase
    endfunction : par_clocks

endpackage : dmfc_pkg

// ---- rtl/dmfc_repair.sv ----
/*
 * Soft row repair table: one replacement row per bank, held in flops.
 * Assumes the caller gates writes on the repair enable and power state.
 */
`timescale 1ns/1ps
`default_nettype none
module dmfc_repair (
    input  wire logic                         clk,
    input  wire logic                         clear,
    input  wire logic                         wr_stb,
    input  wire logic [dmfc_pkg::BANK_W-1:0]  wr_bank,
    input  wire logic [dmfc_pkg::ROW_W-1:0]   wr_row,
    input  wire logic                         act_stb,
    input  wire logic [dmfc_pkg::BANK_W-1:0]  act_bank,
    input  wire logic [dmfc_pkg::ROW_W-1:0]   act_row,
    output logic                              hit
);
    import dmfc_pkg::*;

    // Whole state of the table.
    typedef struct packed {
        logic [BANKS-1:0]            valid;
        logic [BANKS-1:0][ROW_W-1:0] row;
        logic                        hit;
    } dmfc_rep_type;

    dmfc_rep_type s_q;
    dmfc_rep_type s_d;

    // A new address simply overwrites the bank's entry, which undoes the old one.
    always_comb begin
        s_d     = s_q;
        s_d.hit = 1'b0;
        if (wr_stb) begin
            s_d.valid[wr_bank] = 1'b1;
            s_d.row[wr_bank]   = wr_row;
        end
        if (act_stb) begin
            s_d.hit = s_q.valid[act_bank] && (s_q.row[act_bank] == act_row);
        end
        if (clear) begin
            s_d = '0;
        end
    end

    // Register the table.
    always_ff @(posedge clk) begin
        s_q <= s_d;
    end

    assign hit = s_q.hit;

endmodule : dmfc_repair
`default_nettype wire

// ---- rtl/dmfc_top.sv ----
/*
 * Mode-register feature control of one memory die: fourth and fifth
 * mode registers, error status, latency, preamble, refresh and power
 * saving. Assumes commands arrive decoded, one cycle wide, on REF_CLK;
 * only the reset pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
module dmfc_top (
    input  wire logic                        REF_CLK,
    input  wire logic                        SRST,
    input  wire logic                        RESET_N_PIN,
    input  wire logic                        MRS_STB,
    input  wire logic [dmfc_pkg::MR_W-1:0]   MRS_ADDR,
    input  wire logic                        MPS_EXIT_STB,
    input  wire logic                        CS_LOW_STB,
    input  wire logic                        PAR_ERR_STB,
    input  wire logic                        CRC_ERR_STB,
    input  wire logic                        REF_CMD_STB,
    input  wire logic                        TEMP_COOL,
    input  wire logic                        READ_STB,
    input  wire logic                        WRITE_STB,
    input  wire logic                        REPAIR_STB,
    input  wire logic [dmfc_pkg::BANK_W-1:0] REPAIR_BANK,
    input  wire logic [dmfc_pkg::ROW_W-1:0]  REPAIR_ROW,
    input  wire logic                        ACT_STB,
    input  wire logic [dmfc_pkg::BANK_W-1:0] ACT_BANK,
    input  wire logic [dmfc_pkg::ROW_W-1:0]  ACT_ROW,
    input  wire logic                        POWER_DOWN,
    output logic                             REPAIR_HIT,
    output logic                             CA_CAPTURE,
    output logic                             PAR_CHECK_EN,
    output logic                             REF_EXEC,
    output logic                             RD_PREAMBLE,
    output logic                             WR_PREAMBLE,
    output logic                             RD_TRAINING,
    output logic                             IN_MAX_SAVING,
    output logic                             EXT_TEMP_RANGE,
    output logic                             VREF_MONITOR_EN,
    output logic [3:0]                       CAL_CLOCKS,
    output logic [2:0]                       PARITY_LATENCY,
    output logic [7:0]                       MPR_PAGE2_REG0,
    output logic [dmfc_pkg::MR_W-1:0]        MODE_REGISTER_FOUR,
    output logic [dmfc_pkg::MR_W-1:0]        MODE_REGISTER_FIVE
);
    import dmfc_pkg::*;

    // All state of the block in one word.
    typedef struct packed {
        logic          rst_meta;   // First stage of the reset pin synchroniser.
        logic          rst_n;      // Synchronised reset pin level.
        dmfc_mode_type mode;       // Running or in maximum power saving.
        logic [21:0]   mr4;        // Fourth mode register, reserved bits zero.
        logic [21:0]   mr5;        // Fifth mode register, reserved bits zero.
        logic [3:0]    cal_cnt;    // Clocks left until command capture.
        logic          capture;    // Capture pulse.
        logic [1:0]    rd_cnt;     // Read preamble clocks left.
        logic [1:0]    wr_cnt;     // Write preamble clocks left.
        logic          tcr_skip;   // Next cool refresh is skipped.
        logic          ref_exec;   // Refresh executed pulse.
    } dmfc_state_type;

    dmfc_state_type s_q;
    dmfc_state_type s_d;

    logic       run;        // Die accepts commands.
    logic [2:0] sel;        // Register select code of the command.
    logic       mrs_ok;     // Command is accepted.
    logic       perr_set;   // Parity error counted this cycle.
    logic       crc_set;    // CRC error counted this cycle.
    logic       chk_en;     // Parity checking is active.
    logic [3:0] cal_now;    // Programmed latency in clocks.
    logic       rep_clear;  // Wipe of the repair table.
    logic       rep_wr;     // Repair address write.

    // Decode of the command and the checking enable.
    always_comb begin
        run      = (s_q.mode == MODE_RUN);
        sel      = MRS_ADDR[SEL_HI:SEL_LO];
        mrs_ok   = MRS_STB && run;
        cal_now  = cal_clocks(s_q.mr4[MR4_CAL_HI:MR4_CAL_LO]);
        // Checking pauses on a set status unless persistent mode is on.
        chk_en   = run
                   && (par_clocks(s_q.mr5[MR5_PL_HI:MR5_PL_LO]) != 3'h0)
                   && (!s_q.mr5[MR5_PERR] || s_q.mr5[MR5_PERS]);
        perr_set = PAR_ERR_STB && chk_en;
        crc_set  = CRC_ERR_STB && run;
    end

    // Next-state logic for every register of the block.
    always_comb begin
        s_d          = s_q;
        s_d.rst_meta = RESET_N_PIN;
        s_d.rst_n    = s_q.rst_meta;
        s_d.capture  = 1'b0;
        s_d.ref_exec = 1'b0;

        // Preamble counters run down on their own.
        if (s_q.rd_cnt != 2'h0) begin
            s_d.rd_cnt = s_q.rd_cnt - 2'h1;
        end
        if (s_q.wr_cnt != 2'h0) begin
            s_d.wr_cnt = s_q.wr_cnt - 2'h1;
        end

        // Command-address capture countdown.
        if (s_q.cal_cnt != 4'h0) begin
            s_d.cal_cnt = s_q.cal_cnt - 4'h1;
            s_d.capture = (s_q.cal_cnt == 4'h1);
        end

        case (s_q.mode)
            MODE_RUN: begin
                // Mode register writes; only codes 4 and 5 land here.
                if (mrs_ok && (sel == SEL_MR4)) begin
                    s_d.mr4 = MRS_ADDR & MR4_MASK;
                    if (MRS_ADDR[MR4_MPS]) begin
                        s_d.mode = MODE_MAXSAVE;
                    end
                end
                if (mrs_ok && (sel == SEL_MR5)) begin
                    s_d.mr5 = MRS_ADDR & MR5_MASK;
                end
                // Latency zero captures on the next edge.
                if (CS_LOW_STB) begin
                    if (cal_now == 4'h0) begin
                        s_d.capture = 1'b1;
                        s_d.cal_cnt = 4'h0;
                    end else begin
                        s_d.cal_cnt = cal_now - 4'h1;
                    end
                end
                // Preamble length follows the fourth register.
                if (READ_STB) begin
                    s_d.rd_cnt = s_q.mr4[MR4_RPRE] ? 2'h2 : 2'h1;
                end
                if (WRITE_STB) begin
                    s_d.wr_cnt = s_q.mr4[MR4_WPRE] ? 2'h2 : 2'h1;
                end
                // With refresh control on, a cool die drops every other refresh, halving the rate.
                if (REF_CMD_STB) begin
                    if (s_q.mr4[MR4_TCR] && TEMP_COOL) begin
                        s_d.ref_exec = !s_q.tcr_skip;
                        s_d.tcr_skip = !s_q.tcr_skip;
                    end else begin
                        s_d.ref_exec = 1'b1;
                        s_d.tcr_skip = 1'b0;
                    end
                end
            end
            MODE_MAXSAVE: begin
                // Everything but the exit command is dropped.
                s_d.cal_cnt = 4'h0;
                s_d.rd_cnt  = 2'h0;
                s_d.wr_cnt  = 2'h0;
                if (MPS_EXIT_STB) begin
                    s_d.mode            = MODE_RUN;
                    s_d.mr4[MR4_MPS]    = 1'b0;
                end
            end
            default: begin
                s_d.mode = MODE_RUN;
            end
        endcase

        // Events win over a clearing register write in the same cycle.
        if (perr_set) begin
            s_d.mr5[MR5_PERR] = 1'b1;
        end
        if (crc_set) begin
            s_d.mr5[MR5_CRCERR] = 1'b1;
        end

        // The reset pin returns the die to its power-on settings.
        if (!s_q.rst_n) begin
            s_d.mode     = MODE_RUN;
            s_d.mr4      = MR4_RESET;
            s_d.mr5      = MR5_RESET;
            s_d.cal_cnt  = 4'h0;
            s_d.capture  = 1'b0;
            s_d.rd_cnt   = 2'h0;
            s_d.wr_cnt   = 2'h0;
            s_d.tcr_skip = 1'b0;
            s_d.ref_exec = 1'b0;
        end
    end

    // Register the state; the synchroniser starts as if the pin were low.
    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            s_q          <= '0;
            s_q.mode     <= MODE_RUN;
            s_q.mr4      <= MR4_RESET;
            s_q.mr5      <= MR5_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Repair is only written while enabled and running; reset or
    // power-down wipes it, because soft repair is volatile by nature.
    assign rep_clear = SRST || !s_q.rst_n || POWER_DOWN;
    assign rep_wr    = REPAIR_STB && run && s_q.mr4[MR4_SOFT_ROW_REPAIR];

    dmfc_repair u_repair (
        .clk      (REF_CLK),
        .clear    (rep_clear),
        .wr_stb   (rep_wr),
        .wr_bank  (REPAIR_BANK),
        .wr_row   (REPAIR_ROW),
        .act_stb  (ACT_STB && run),
        .act_bank (ACT_BANK),
        .act_row  (ACT_ROW),
        .hit      (REPAIR_HIT)
    );

    // Outputs, all taken from the registered state.
    always_comb begin
        MPR_PAGE2_REG0               = 8'h00;
        MPR_PAGE2_REG0[MPR_SOFT_ROW_REPAIR_BIT] = SOFT_ROW_REPAIR_SUPPORTED;
        MODE_REGISTER_FOUR           = s_q.mr4;
        MODE_REGISTER_FOUR[SEL_HI:SEL_LO] = SEL_MR4;
        MODE_REGISTER_FIVE           = s_q.mr5;
        MODE_REGISTER_FIVE[SEL_HI:SEL_LO] = SEL_MR5;
        CA_CAPTURE                   = s_q.capture;
        PAR_CHECK_EN                 = chk_en;
        REF_EXEC                     = s_q.ref_exec;
        RD_PREAMBLE                  = (s_q.rd_cnt != 2'h0);
        WR_PREAMBLE                  = (s_q.wr_cnt != 2'h0);
        RD_TRAINING                  = s_q.mr4[MR4_RTRAIN];
        IN_MAX_SAVING                = (s_q.mode == MODE_MAXSAVE);
        EXT_TEMP_RANGE               = s_q.mr4[MR4_TRANGE];
        VREF_MONITOR_EN              = s_q.mr4[MR4_VMON];
        CAL_CLOCKS                   = cal_now;
        PARITY_LATENCY               = par_clocks(s_q.mr5[MR5_PL_HI:MR5_PL_LO]);
    end

    // Checks on the registered behaviour.
    logic pin_low;
    assign pin_low = !s_q.rst_n;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (SRST || pin_low);

    sequence s_mr5_write;
        MRS_STB && !IN_MAX_SAVING && (MRS_ADDR[SEL_HI:SEL_LO] == SEL_MR5);
    endsequence

    sequence s_cs_four;
        (CS_LOW_STB && !IN_MAX_SAVING && CAL_CLOCKS == 4'h4) ##1 (!CS_LOW_STB) [*3];
    endsequence

    property p_mr5_fields;
        s_mr5_write |=> MODE_REGISTER_FIVE[12:5] == $past(MRS_ADDR[12:5]);
    endproperty
    a_mr5_fields: assert property (p_mr5_fields)
        else $error("fifth register fields not taken from the command");

    property p_other_sel;
        MRS_STB && (MRS_ADDR[SEL_HI:SEL_LO] != SEL_MR5) && !PAR_ERR_STB && !CRC_ERR_STB
            |=> $stable(MODE_REGISTER_FIVE);
    endproperty
    a_other_sel: assert property (p_other_sel)
        else $error("fifth register changed by another select code");

    property p_mps_ignore;
        IN_MAX_SAVING && !MPS_EXIT_STB |=> IN_MAX_SAVING && $stable(MODE_REGISTER_FOUR);
    endproperty
    a_mps_ignore: assert property (p_mps_ignore)
        else $error("command acted on during power saving");

    property p_mps_exit;
        IN_MAX_SAVING && MPS_EXIT_STB |=> !IN_MAX_SAVING;
    endproperty
    a_mps_exit: assert property (p_mps_exit)
        else $error("exit command did not leave power saving");

    // A clearing fifth-register write right after the event may legally drop the bit.
    property p_perr_sticky;
        (PAR_ERR_STB && PAR_CHECK_EN)
            ##1 !(MRS_STB && !IN_MAX_SAVING && (MRS_ADDR[SEL_HI:SEL_LO] == SEL_MR5))
            |-> MODE_REGISTER_FIVE[MR5_PERR] [*2];
    endproperty
    a_perr_sticky: assert property (p_perr_sticky)
        else $error("parity error status not set and held");

    property p_crc_sticky;
        CRC_ERR_STB && !IN_MAX_SAVING |=> MODE_REGISTER_FIVE[MR5_CRCERR];
    endproperty
    a_crc_sticky: assert property (p_crc_sticky)
        else $error("crc error status not set");

    property p_check_pause;
        MODE_REGISTER_FIVE[MR5_PERR] && !MODE_REGISTER_FIVE[MR5_PERS] |-> !PAR_CHECK_EN;
    endproperty
    a_check_pause: assert property (p_check_pause)
        else $error("parity checked while status set and not persistent");

    property p_cal_four;
        s_cs_four |=> CA_CAPTURE;
    endproperty
    a_cal_four: assert property (p_cal_four)
        else $error("command not captured four clocks after select");

    property p_wr_pre_two;
        (WRITE_STB && !IN_MAX_SAVING && MODE_REGISTER_FOUR[MR4_WPRE]) ##1 !WRITE_STB
            |-> WR_PREAMBLE ##1 WR_PREAMBLE;
    endproperty
    a_wr_pre_two: assert property (p_wr_pre_two)
        else $error("two-clock write preamble not held for two clocks");

    property p_rd_pre_one;
        (READ_STB && !IN_MAX_SAVING && !MODE_REGISTER_FOUR[MR4_RPRE]) ##1 !READ_STB
            |-> RD_PREAMBLE ##1 !RD_PREAMBLE;
    endproperty
    a_rd_pre_one: assert property (p_rd_pre_one)
        else $error("one-clock read preamble has wrong length");

    // Further checks on refresh, parity decode, repair and power saving.
    property p_ref_plain;
        REF_CMD_STB && !IN_MAX_SAVING && !(MODE_REGISTER_FOUR[MR4_TCR] && TEMP_COOL)
            |=> REF_EXEC;
    endproperty
    a_ref_plain: assert property (p_ref_plain)
        else $error("refresh dropped although no cool skip applies");

    property p_par_reserved;
        MODE_REGISTER_FIVE[MR5_PL_HI] |-> (PARITY_LATENCY == 3'h0) && !PAR_CHECK_EN;
    endproperty
    a_par_reserved: assert property (p_par_reserved)
        else $error("reserved parity latency code not treated as off");

    property p_pd_revoke;
        POWER_DOWN |=> !REPAIR_HIT;
    endproperty
    a_pd_revoke: assert property (p_pd_revoke)
        else $error("repaired row still hit after power-down");

    property p_mr5_save;
        IN_MAX_SAVING && !MPS_EXIT_STB |=> $stable(MODE_REGISTER_FIVE);
    endproperty
    a_mr5_save: assert property (p_mr5_save)
        else $error("fifth register changed during power saving");

endmodule : dmfc_top
`default_nettype wire
